// File: src/ge_pkg.sv
// Purpose: Shared constants of the 2-D engine setup and raster-operation core
// Assumes: 32-bit register port, word-aligned byte offsets
// Notes:   Offsets are byte addresses; registers decode all eight address bits, only the host port window ignores bits 1:0 for ports 0 to 6
package ge_pkg;
   // Register offsets
   localparam logic [7:0] OFS_ENGINE_CONTROL    = 8'h00;
   localparam logic [7:0] OFS_ENGINE_TRIGGER    = 8'h04;
   localparam logic [7:0] OFS_ENGINE_IRQ_STATUS = 8'h08;
   localparam logic [7:0] OFS_IRQ_MASK          = 8'h0C;
   localparam logic [7:0] OFS_PATTERN_START     = 8'h10;
   localparam logic [7:0] OFS_TRANSP_MASK       = 8'h30;
   localparam logic [7:0] OFS_XY_MEM_ORIGIN     = 8'h34;
   localparam logic [7:0] OFS_SRC_DST_PITCH     = 8'h38;
   localparam logic [7:0] OFS_SOURCE_START      = 8'h3C;
   localparam logic [7:0] OFS_DEST_START        = 8'h40;
   localparam logic [7:0] OFS_RECT_SIZE         = 8'h44;
   localparam logic [7:0] OFS_CLIP_TOP_LEFT     = 8'h48;
   localparam logic [7:0] OFS_CLIP_BOT_RIGHT    = 8'h4C;
   localparam logic [7:0] OFS_PATTERN_A         = 8'h50;
   localparam logic [7:0] OFS_PATTERN_B         = 8'h54;
   localparam logic [7:0] OFS_WRITE_PLANE_MASK  = 8'h58;
   localparam logic [7:0] OFS_MISC_CONTROL      = 8'h5C;
   localparam logic [7:0] OFS_HOST_PORT_FIRST   = 8'h60;
   localparam logic [7:0] OFS_HOST_PORT_LAST    = 8'h7C;
   localparam int         HOST_PORTS            = 8;

   // Field positions
   localparam int ROP_LSB       = 24;
   localparam int IRQ_EN_BIT    = 17;
   localparam int TRIGGER_BIT   = 0;
   localparam int DONE_BIT      = 0;
   localparam int BPP_LSB       = 4;
   localparam int RECT_Y_LSB    = 16;
   localparam int PAT_SIDE_LOG2 = 3;

   // Reset values
   localparam logic [31:0] RST_WORD       = 32'h0000_0000;
   localparam logic [31:0] RST_PLANE_MASK = 32'h0000_0000;

   // Pixel depth codes of the two-bit field
   localparam logic [1:0] BPP_8  = 2'h0;
   localparam logic [1:0] BPP_16 = 2'h1;
   localparam logic [1:0] BPP_32 = 2'h2;

   // Well-known raster-operation codes
   localparam logic [7:0] ROP_ALL_ZERO      = 8'h00;
   localparam logic [7:0] dest_invert_code  = 8'h55;
   localparam logic [7:0] ROP_SRC_XOR_DST   = 8'h66;
   localparam logic [7:0] ROP_SRC_AND_DST   = 8'h88;
   localparam logic [7:0] source_copy_code  = 8'hCC;
   localparam logic [7:0] pattern_copy_code = 8'hF0;
   localparam logic [7:0] ROP_ALL_ONE       = 8'hFF;

   // Log2 of bytes per pixel; the unused code falls back to four bytes
   function automatic logic [1:0] bpp_shift(input logic [1:0] code);
      logic [1:0] s;
      s = 2'h2;
      if (code == BPP_8) begin
         s = 2'h0;
      end else if (code == BPP_16) begin
         s = 2'h1;
      end
      return s;
   endfunction : bpp_shift
endpackage : ge_pkg

// File: src/rop_unit.sv
// Purpose: Ternary raster-operation unit, one lookup per data bit
// Assumes: Inputs are stable for the cycle they are sampled
// Notes:   Purely combinational; the caller registers the result
`timescale 1ns/1ps
module rop_unit
   import ge_pkg::*;
#(
   parameter int W = 32
) (
   // Operation code
   input  wire logic [7:0]   raster_op_code,
   // Operands
   input  wire logic [W-1:0] src,
   input  wire logic [W-1:0] pat,
   input  wire logic [W-1:0] dst,
   // Result
   output logic      [W-1:0] res
);
   // Each result bit picks one code bit, so all 256 functions come for free
   for (genvar i = 0; i < W; i++) begin : g_bit
      assign res[i] = raster_op_code[{pat[i], src[i], dst[i]}];
   end
endmodule : rop_unit

// File: src/pixel_walker.sv
// Purpose: Walks a rectangle pixel by pixel and tracks the pattern cell
// Assumes: start and step never coincide
// Notes:   A zero dimension wraps and walks the full 65536 span
`timescale 1ns/1ps
module pixel_walker
   import ge_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        reset_n,
   // Control
   input  wire logic        start,
   input  wire logic        step,
   input  wire logic [15:0] width,
   input  wire logic [15:0] height,
   // Position
   output logic      [5:0]  pat_index,
   output logic             last
);
   logic [15:0] x_q;
   logic [15:0] y_q;

   // Row-major walk, restarted by every accepted trigger
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         x_q <= 16'h0000;
         y_q <= 16'h0000;
      end else if (start) begin
         x_q <= 16'h0000;
         y_q <= 16'h0000;
      end else if (step) begin
         if (x_q == width - 16'h0001) begin
            x_q <= 16'h0000;
            y_q <= y_q + 16'h0001;
         end else begin
            x_q <= x_q + 16'h0001;
         end
      end
   end

   // Pattern repeats every eight pixels in both directions
   assign pat_index = {y_q[PAT_SIDE_LOG2-1:0], x_q[PAT_SIDE_LOG2-1:0]};
   assign last      = (x_q == width - 16'h0001) && (y_q == height - 16'h0001);
endmodule : pixel_walker

// File: src/ge_core.sv
// Purpose: Register file, operation sequencing and pixel datapath of the 2-D engine
// Assumes: Register port master follows one-cycle strobes; engine clock already enabled
// Notes:   Pixels arrive as a stream of source, pattern and destination words
//
// Operation
// - A colour pattern is an 8x8 pixel block read from the pattern start address.
// - Completion shows in bit 0 of the status register, cleared by software before use.
// - The interrupt is raised only while control bit 17 is one.
// - A destination bit plane is written only where the plane mask bit is one.
// - Bytes per pixel and byte counts follow misc control bits 5 to 4.
// - The raster unit implements all 256 three-input Boolean functions.
// - The code in control bits 31 to 24 always applies during transfers.
// - Named codes give their standard results such as source copy and pattern copy.
// - Writing one to trigger bit 0 starts the programmed operation.
// - The completion flag clears when software writes a one to it.
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
module ge_core
   import ge_pkg::*;
#(
   parameter int DATA_W = 32
) (
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              reset_n,
   // Register port
   input  wire logic [7:0]        reg_addr,
   input  wire logic [31:0]       reg_wdata,
   input  wire logic              reg_write,
   input  wire logic              reg_read,
   output logic      [31:0]       reg_rdata,
   // Pixel operand stream
   input  wire logic              px_valid,
   output logic                   px_ready,
   input  wire logic [DATA_W-1:0] src_px,
   input  wire logic [DATA_W-1:0] pat_px,
   input  wire logic [DATA_W-1:0] dst_px,
   // Pattern fetch address
   output logic      [31:0]       pat_addr,
   // Result stream
   output logic                   res_valid,
   output logic      [DATA_W-1:0] res_px,
   output logic      [2:0]        res_bytes,
   // Status
   output logic                   busy,
   output logic                   irq
);
   // Programmable state
   logic [31:0]              engine_control_q;
   logic [31:0]              irq_mask_q;
   logic [31:0]              pattern_start_addr_q;
   logic [31:0]              transparency_color_mask_q;
   logic [31:0]              xy_memory_origin_q;
   logic [31:0]              src_dst_pitch_q;
   logic [31:0]              source_start_point_q;
   logic [31:0]              dest_start_point_q;
   logic [31:0]              rectangle_size_q;
   logic [31:0]              clip_top_left_q;
   logic [31:0]              clip_bottom_right_q;
   logic [31:0]              pattern_group_a_q;
   logic [31:0]              pattern_group_b_q;
   logic [31:0]              write_plane_mask_q;
   logic [31:0]              misc_control_q;
   logic [31:0]              host_data_q [HOST_PORTS];

   // Engine state
   logic                     busy_q;
   logic                     op_done_flag_q;
   logic                     px_ready_q;
   logic                     irq_q;
   logic [31:0]              reg_rdata_q;
   logic [31:0]              pat_addr_q;
   logic                     res_valid_q;
   logic [DATA_W-1:0]        res_px_q;
   logic [2:0]               res_bytes_q;

   // Decode and datapath nets
   logic                     host_hit;
   logic [2:0]               host_idx;
   logic                     start;
   logic                     step;
   logic                     last;
   logic [5:0]               pat_index;
   logic [1:0]               shift;
   logic [7:0]               raster_op_code;
   logic [DATA_W-1:0]        rop_res;
   logic [DATA_W-1:0]        plane_mask;
   logic [DATA_W-1:0]        merged;
   logic [31:0]              read_word;

   // Address decode of the data-port window
   assign host_hit = (reg_addr >= OFS_HOST_PORT_FIRST) && (reg_addr <= OFS_HOST_PORT_LAST);
   assign host_idx = reg_addr[4:2];

   // A start while busy is ignored so a running walk is never disturbed
   assign start = reg_write && (reg_addr == OFS_ENGINE_TRIGGER)
                  && reg_wdata[TRIGGER_BIT] && !busy_q;
   assign step  = px_ready_q && px_valid;

   // Current configuration seen by the datapath
   assign raster_op_code = engine_control_q[ROP_LSB +: 8];
   assign shift          = bpp_shift(misc_control_q[BPP_LSB +: 2]);
   assign plane_mask     = write_plane_mask_q[DATA_W-1:0];

   // Control register
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         engine_control_q <= RST_WORD;
      end else if (reg_write && reg_addr == OFS_ENGINE_CONTROL) begin
         engine_control_q <= reg_wdata;
      end
   end

   // Interrupt mask register
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         irq_mask_q <= RST_WORD;
      end else if (reg_write && reg_addr == OFS_IRQ_MASK) begin
         irq_mask_q <= reg_wdata;
      end
   end

   // Plain setup registers; most feed datapath pieces outside this core
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pattern_start_addr_q      <= RST_WORD;
         transparency_color_mask_q <= RST_WORD;
         xy_memory_origin_q        <= RST_WORD;
         src_dst_pitch_q           <= RST_WORD;
         source_start_point_q      <= RST_WORD;
         dest_start_point_q        <= RST_WORD;
         rectangle_size_q          <= RST_WORD;
         clip_top_left_q           <= RST_WORD;
         clip_bottom_right_q       <= RST_WORD;
         pattern_group_a_q         <= RST_WORD;
         pattern_group_b_q         <= RST_WORD;
         write_plane_mask_q        <= RST_PLANE_MASK;
         misc_control_q            <= RST_WORD;
      end else if (reg_write) begin
         unique case (reg_addr)
            OFS_PATTERN_START:    pattern_start_addr_q      <= reg_wdata;
            OFS_TRANSP_MASK:      transparency_color_mask_q <= reg_wdata;
            OFS_XY_MEM_ORIGIN:    xy_memory_origin_q        <= reg_wdata;
            OFS_SRC_DST_PITCH:    src_dst_pitch_q           <= reg_wdata;
            OFS_SOURCE_START:     source_start_point_q      <= reg_wdata;
            OFS_DEST_START:       dest_start_point_q        <= reg_wdata;
            OFS_RECT_SIZE:        rectangle_size_q          <= reg_wdata;
            OFS_CLIP_TOP_LEFT:    clip_top_left_q           <= reg_wdata;
            OFS_CLIP_BOT_RIGHT:   clip_bottom_right_q       <= reg_wdata;
            OFS_PATTERN_A:        pattern_group_a_q         <= reg_wdata;
            OFS_PATTERN_B:        pattern_group_b_q         <= reg_wdata;
            OFS_WRITE_PLANE_MASK: write_plane_mask_q        <= reg_wdata;
            OFS_MISC_CONTROL:     misc_control_q            <= reg_wdata;
            default: ;
         endcase
      end
   end

   // Host data ports, one flop word per port
   for (genvar p = 0; p < HOST_PORTS; p++) begin : g_host
      always_ff @(posedge clk or negedge reset_n) begin
         if (!reset_n) begin
            host_data_q[p] <= RST_WORD;
         end else if (reg_write && host_hit && host_idx == 3'(p)) begin
            host_data_q[p] <= reg_wdata;
         end
      end
   end

   // Busy runs from the trigger until the last pixel of the rectangle
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         busy_q <= 1'b0;
      end else if (start) begin
         busy_q <= 1'b1;
      end else if (step && last) begin
         busy_q <= 1'b0;
      end
   end

   // Ready comes from a flop; the idle cycle after each pixel lets the pattern address settle
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         px_ready_q <= 1'b0;
      end else begin
         px_ready_q <= start || (busy_q && !step);
      end
   end

   // Completion flag: the set wins over a same-cycle write-one clear
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         op_done_flag_q <= 1'b0;
      end else if (step && last) begin
         op_done_flag_q <= 1'b1;
      end else if (reg_write && reg_addr == OFS_ENGINE_IRQ_STATUS && reg_wdata[DONE_BIT]) begin
         op_done_flag_q <= 1'b0;
      end
   end

   // Level interrupt, gated by both the mask and the control enable bit
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= op_done_flag_q && irq_mask_q[DONE_BIT]
                  && engine_control_q[IRQ_EN_BIT];
      end
   end

   // Pattern fetch address: one 8x8 block, scaled by bytes per pixel
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pat_addr_q <= RST_WORD;
      end else begin
         pat_addr_q <= pattern_start_addr_q + ({26'h0, pat_index} << shift);
      end
   end

   pixel_walker u_walker (
      .clk       (clk),
      .reset_n   (reset_n),
      .start     (start),
      .step      (step),
      .width     (rectangle_size_q[15:0]),
      .height    (rectangle_size_q[RECT_Y_LSB +: 16]),
      .pat_index (pat_index),
      .last      (last)
   );

   rop_unit #(
      .W (DATA_W)
   ) u_rop (
      .raster_op_code (raster_op_code),
      .src            (src_px),
      .pat            (pat_px),
      .dst            (dst_px),
      .res            (rop_res)
   );

   // Masked planes keep the old destination bit
   assign merged = (rop_res & plane_mask) | (dst_px & ~plane_mask);

   // Result stream, one word per accepted pixel
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         res_valid_q <= 1'b0;
         res_px_q    <= '0;
         res_bytes_q <= 3'h0;
      end else begin
         res_valid_q <= step;
         if (step) begin
            res_px_q    <= merged;
            res_bytes_q <= 3'(3'h1 << shift);
         end
      end
   end

   // Read multiplexer; unmapped addresses read as zero
   always_comb begin
      read_word = RST_WORD;
      if (host_hit) begin
         read_word = host_data_q[host_idx];
      end else begin
         unique case (reg_addr)
            OFS_ENGINE_CONTROL:    read_word = engine_control_q;
            OFS_ENGINE_TRIGGER:    read_word = {31'h0, busy_q};
            OFS_ENGINE_IRQ_STATUS: read_word = {31'h0, op_done_flag_q};
            OFS_IRQ_MASK:          read_word = irq_mask_q;
            OFS_PATTERN_START:     read_word = pattern_start_addr_q;
            OFS_TRANSP_MASK:       read_word = transparency_color_mask_q;
            OFS_XY_MEM_ORIGIN:     read_word = xy_memory_origin_q;
            OFS_SRC_DST_PITCH:     read_word = src_dst_pitch_q;
            OFS_SOURCE_START:      read_word = source_start_point_q;
            OFS_DEST_START:        read_word = dest_start_point_q;
            OFS_RECT_SIZE:         read_word = rectangle_size_q;
            OFS_CLIP_TOP_LEFT:     read_word = clip_top_left_q;
            OFS_CLIP_BOT_RIGHT:    read_word = clip_bottom_right_q;
            OFS_PATTERN_A:         read_word = pattern_group_a_q;
            OFS_PATTERN_B:         read_word = pattern_group_b_q;
            OFS_WRITE_PLANE_MASK:  read_word = write_plane_mask_q;
            OFS_MISC_CONTROL:      read_word = misc_control_q;
            default:               read_word = RST_WORD;
         endcase
      end
   end

   // Read data stand only in the cycle after the strobe
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         reg_rdata_q <= RST_WORD;
      end else if (reg_read) begin
         reg_rdata_q <= read_word;
      end else begin
         reg_rdata_q <= RST_WORD;
      end
   end

   // Outputs straight from flops
   assign reg_rdata = reg_rdata_q;
   assign px_ready  = px_ready_q;
   assign pat_addr  = pat_addr_q;
   assign res_valid = res_valid_q;
   assign res_px    = res_px_q;
   assign res_bytes = res_bytes_q;
   assign busy      = busy_q;
   assign irq       = irq_q;
endmodule : ge_core

// File: tb/ge_core_properties.sv
// Purpose: Port-level checks of the 2-D engine core
// Assumes: Control, plane mask, depth and irq mask change only by register writes
// Notes:   Shadows a few fields from the write strobe because the core internals are hidden
`timescale 1ns/1ps
module ge_core_properties
   import ge_pkg::*;
#(
   parameter int DATA_W = 32
) (
   // Clock and reset
   input wire logic              clk,
   input wire logic              reset_n,
   // Register port
   input wire logic [7:0]        reg_addr,
   input wire logic [31:0]       reg_wdata,
   input wire logic              reg_write,
   input wire logic              reg_read,
   input wire logic [31:0]       reg_rdata,
   // Pixel streams
   input wire logic              px_valid,
   input wire logic              px_ready,
   input wire logic [DATA_W-1:0] src_px,
   input wire logic [DATA_W-1:0] pat_px,
   input wire logic [DATA_W-1:0] dst_px,
   input wire logic [31:0]       pat_addr,
   input wire logic              res_valid,
   input wire logic [DATA_W-1:0] res_px,
   input wire logic [2:0]        res_bytes,
   // Status
   input wire logic              busy,
   input wire logic              irq
);
   logic [31:0]       ctrl_q;
   logic [DATA_W-1:0] plane_q;
   logic [1:0]        bpp_q;
   logic              imask_q;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   // Own lookup so a shared slip in the core cannot hide itself
   function automatic logic [DATA_W-1:0] rop_f(input logic [7:0] c, input logic [DATA_W-1:0] s, p, d);
      for (int i = 0; i < DATA_W; i++) rop_f[i] = c[{p[i], s[i], d[i]}];
   endfunction : rop_f

   // Shadow copies of the fields that steer results and the interrupt
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_q  <= 32'h0;
         plane_q <= '0;
         bpp_q   <= 2'h0;
         imask_q <= 1'b0;
      end else if (reg_write) begin
         if (reg_addr == OFS_ENGINE_CONTROL) ctrl_q <= reg_wdata;
         if (reg_addr == OFS_WRITE_PLANE_MASK) plane_q <= DATA_W'(reg_wdata);
         if (reg_addr == OFS_MISC_CONTROL) bpp_q <= reg_wdata[BPP_LSB+1:BPP_LSB];
         if (reg_addr == OFS_IRQ_MASK) imask_q <= reg_wdata[0];
      end
   end

   property p_irq_gate; irq |-> $past(ctrl_q[IRQ_EN_BIT]) && $past(imask_q); endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("irq without enable");
   property p_done_irq; $fell(busy) && ctrl_q[IRQ_EN_BIT] && imask_q |=> irq; endproperty
   a_done_irq: assert property (p_done_irq) else $error("no irq after done");
   property p_status_read; $past(reg_read) && $past(reg_addr) == OFS_ENGINE_IRQ_STATUS |-> reg_rdata[31:1] == 31'h0;
   endproperty
   a_status_read: assert property (p_status_read) else $error("status upper bits set");
   property p_res_cause; res_valid |-> $past(px_valid) && $past(px_ready); endproperty
   a_res_cause: assert property (p_res_cause) else $error("result without pixel");
   property p_rop_bits;
      res_valid |-> ((res_px ^ rop_f(ctrl_q[31:24], $past(src_px), $past(pat_px), $past(dst_px))) & plane_q) == '0;
   endproperty
   a_rop_bits: assert property (p_rop_bits) else $error("wrong raster result");
   property p_mask_keep; res_valid |-> ((res_px ^ $past(dst_px)) & ~plane_q) == '0; endproperty
   a_mask_keep: assert property (p_mask_keep) else $error("masked plane changed");
   property p_bytes; res_valid |-> res_bytes == (bpp_q == BPP_8 ? 3'h1 : bpp_q == BPP_16 ? 3'h2 : 3'h4); endproperty
   a_bytes: assert property (p_bytes) else $error("wrong byte count");
   property p_start; reg_write && reg_addr == OFS_ENGINE_TRIGGER && reg_wdata[TRIGGER_BIT] && !busy |=> busy;
   endproperty
   a_start: assert property (p_start) else $error("trigger did not start");
   property p_no_start; reg_write && reg_addr == OFS_ENGINE_TRIGGER && !reg_wdata[TRIGGER_BIT] && !busy |=> !busy;
   endproperty
   a_no_start: assert property (p_no_start) else $error("started without go bit");

   c_irq: cover property (irq);
   c_wide: cover property (res_valid && res_bytes == 3'h4);
   c_done: cover property ($fell(busy));
endmodule : ge_core_properties

bind ge_core ge_core_properties #(.DATA_W(DATA_W)) u_props (
   .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
   .reg_read(reg_read), .reg_rdata(reg_rdata), .px_valid(px_valid), .px_ready(px_ready), .src_px(src_px),
   .pat_px(pat_px), .dst_px(dst_px), .pat_addr(pat_addr), .res_valid(res_valid), .res_px(res_px),
   .res_bytes(res_bytes), .busy(busy), .irq(irq)
);

// File: tb/mem_pixel_model.sv
// Purpose: System memory side feeding source, pattern and destination words
// Assumes: A word is taken at an edge with px_valid and px_ready high
// Notes:   slow adds fetch latency so the pattern address has settled before a word
`timescale 1ns/1ps
module mem_pixel_model #(
   parameter logic [31:0] SRC_W = 32'hCCCC_CCCC,
   parameter logic [31:0] PAT_W = 32'hF0F0_F0F0,
   parameter logic [31:0] DST_W = 32'hAAAA_AAAA
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        reset_n,
   // Fetch control
   input  wire logic        slow,
   input  wire logic [31:0] pat_addr,
   output logic      [31:0] seen_addr,
   // Operand stream
   input  wire logic        px_ready,
   output logic             px_valid,
   output logic      [31:0] src_px,
   output logic      [31:0] pat_px,
   output logic      [31:0] dst_px
);
   logic [1:0] wait_q;

   // Hold a word until taken; inverted junk between words so stale data never passes
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         px_valid <= 1'b0;
         wait_q   <= 2'h0;
      end else if (px_valid && px_ready) begin
         px_valid  <= 1'b0;
         wait_q    <= slow ? 2'h3 : 2'h0;
         seen_addr <= pat_addr;
         src_px    <= ~src_px;
         pat_px    <= ~pat_px;
         dst_px    <= ~dst_px;
      end else if (wait_q != 2'h0) begin
         wait_q <= wait_q - 2'h1;
      end else if (!px_valid) begin
         px_valid <= 1'b1;
         src_px   <= SRC_W;
         pat_px   <= PAT_W;
         dst_px   <= DST_W;
      end
   end
endmodule : mem_pixel_model

// File: tb/graphics_2d_setup_rop_test.sv
// Purpose: Self-checking bench of the 2-D engine core
// Assumes: Operand words chosen so each result byte equals the raster code
// Notes:   Register port driven at the rising edge; read data taken the cycle after
`timescale 1ns/1ps
module graphics_2d_setup_rop_test;
   import ge_pkg::*;
   logic        clk, reset_n, reg_write, reg_read, slow, px_valid, px_ready, res_valid, busy, irq;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata, src_px, pat_px, dst_px, pat_addr, seen_addr, res_px;
   logic [2:0]  res_bytes;
   int          fails, n_tests, n_res, cyc;

   ge_core #(.DATA_W(32)) dut (
      .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
      .reg_read(reg_read), .reg_rdata(reg_rdata), .px_valid(px_valid), .px_ready(px_ready), .src_px(src_px),
      .pat_px(pat_px), .dst_px(dst_px), .pat_addr(pat_addr), .res_valid(res_valid), .res_px(res_px),
      .res_bytes(res_bytes), .busy(busy), .irq(irq));
   mem_pixel_model u_mem (
      .clk(clk), .reset_n(reset_n), .slow(slow), .pat_addr(pat_addr), .seen_addr(seen_addr),
      .px_ready(px_ready), .px_valid(px_valid), .src_px(src_px), .pat_px(pat_px), .dst_px(dst_px));

   // Clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // Result pulses and hang guard
   always @(posedge clk) begin
      if (res_valid === 1'b1) n_res++;
      cyc++;
      if (cyc == 20000) begin
         fails++;
         finish_test();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clk);
      reg_write <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk);
      reg_read <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd

   // Run one rectangle until the engine is idle
   task automatic run_op(input logic [31:0] rect);
      wr(OFS_RECT_SIZE, rect);
      n_res = 0;
      wr(OFS_ENGINE_TRIGGER, 32'h1);
      @(posedge clk);
      while (busy === 1'b1) @(posedge clk);
      repeat (2) @(posedge clk);
      #1;
   endtask : run_op

   task automatic t_regs;
      logic [31:0] d;
      for (int a = 'h30; a <= 'h7C; a += 4) begin
         rd(8'(a), d);
         chk(d, RST_WORD);
         wr(8'(a), {8'(a), 8'hA5, ~8'(a), 8'h3C});
         rd(8'(a), d);
         chk(d, {8'(a), 8'hA5, ~8'(a), 8'h3C});
      end
      wr(8'h20, 32'hFFFF_FFFF);
      rd(8'h20, d);
      chk(d, 32'h0);
      rd(OFS_ENGINE_IRQ_STATUS, d);
      chk(d, 32'h0);
   endtask : t_regs

   task automatic t_rop;
      wr(OFS_WRITE_PLANE_MASK, 32'hFFFF_FFFF);
      for (int c = 0; c < 256; c++) begin
         wr(OFS_ENGINE_CONTROL, {8'(c), 24'h0});
         run_op(32'h0001_0001);
         chk(res_px, {4{8'(c)}});
      end
      wr(OFS_WRITE_PLANE_MASK, 32'h00FF_00FF);
      wr(OFS_ENGINE_CONTROL, {ROP_ALL_ONE, 24'h0});
      run_op(32'h0001_0001);
      chk(res_px, 32'hAAFF_AAFF);
   endtask : t_rop

   // Slow memory so the pattern address is settled when the last word is taken
   task automatic t_bpp;
      slow <= 1'b1;
      wr(OFS_PATTERN_START, 32'h0000_1000);
      for (int b = 0; b < 3; b++) begin
         wr(OFS_MISC_CONTROL, 32'(b) << BPP_LSB);
         run_op(32'h0002_000A);
         chk(32'(n_res), 32'd20);
         chk({29'h0, res_bytes}, 32'h1 << b);
         chk(seen_addr, 32'h1000 + (32'h9 << b));
      end
      slow <= 1'b0;
   endtask : t_bpp

   task automatic t_busy;
      logic [31:0] d;
      wr(OFS_RECT_SIZE, 32'h0001_0004);
      n_res = 0;
      wr(OFS_ENGINE_TRIGGER, 32'h1);
      wr(OFS_ENGINE_TRIGGER, 32'h1);
      rd(OFS_ENGINE_TRIGGER, d);
      chk(d, 32'h1);
      while (busy === 1'b1) @(posedge clk);
      repeat (2) @(posedge clk);
      chk(32'(n_res), 32'd4);
   endtask : t_busy

   task automatic t_irq;
      logic [31:0] d;
      wr(OFS_ENGINE_IRQ_STATUS, 32'h1);
      wr(OFS_IRQ_MASK, 32'h1);
      wr(OFS_ENGINE_CONTROL, {source_copy_code, 24'h02_0000});
      wr(OFS_ENGINE_TRIGGER, 32'h0);
      #1 chk({31'h0, busy}, 32'h0);
      run_op(32'h0001_0001);
      rd(OFS_ENGINE_IRQ_STATUS, d);
      chk(d, 32'h1);
      chk({31'h0, irq}, 32'h1);
      wr(OFS_ENGINE_IRQ_STATUS, 32'h1);
      rd(OFS_ENGINE_IRQ_STATUS, d);
      chk(d, 32'h0);
      chk({31'h0, irq}, 32'h0);
      wr(OFS_ENGINE_CONTROL, {source_copy_code, 24'h0});
      run_op(32'h0001_0001);
      chk({31'h0, irq}, 32'h0);
      wr(OFS_IRQ_MASK, 32'h0);
      wr(OFS_ENGINE_CONTROL, {source_copy_code, 24'h02_0000});
      rd(OFS_ENGINE_IRQ_STATUS, d);
      chk({31'h0, irq}, 32'h0);
      wr(OFS_IRQ_MASK, 32'h1);
      rd(OFS_ENGINE_IRQ_STATUS, d);
      chk({31'h0, irq}, 32'h1);
   endtask : t_irq

   task automatic finish_test;
      $display("Checks %0d, mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : finish_test

   // Main sequence
   initial begin
      reset_n = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      reg_write = 1'b0;
      reg_read = 1'b0;
      slow = 1'b0;
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      t_regs();
      wr(OFS_XY_MEM_ORIGIN, 32'h0012_0000);
      t_rop();
      t_bpp();
      t_busy();
      t_irq();
      finish_test();
   end
endmodule : graphics_2d_setup_rop_test
